// file: sim/test_tv_graphics_bus_sequencer.sv
/*
 * Self-checking bench for the display-fetch bus sequencer.
 * Assumes the memory model as the only other party on the bus.
 */
`timescale 1ns/1ps
`include "tvgbs_defines.svh"
`default_nettype none
module test_tv_graphics_bus_sequencer;
    logic clk, srst, frame, extra, cnt_en, infr;
    logic [2:0] code; // Processor code as {dir, one, two}
    logic [13:0] bus, dout, lat;
    logic oe, hand, row_n, chr, adr, rd_n, wr_n, val;
    logic [7:0] pat;
    int num_errors, checks, n_row, n_chr, n_adr, n_rd, n_wr, n_hand, n_val, n_oe;

    tvgbs_sequencer DUT (.clk_i(clk), .srst_i(srst), .frame_start_i(frame),
        .row_extra_i(extra), .cpu_bus_direction_i(code[2]), .cpu_ctl_line_one_i(code[1]),
        .cpu_ctl_line_two_i(code[0]), .bus_in_i(bus), .bus_out_o(dout), .bus_oe_o(oe),
        .frame_handoff_strobe_o(hand), .row_fetch_request_n_o(row_n),
        .char_fetch_strobe_o(chr), .gfx_addr_strobe_o(adr), .gfx_read_strobe_n_o(rd_n),
        .gfx_write_strobe_n_o(wr_n), .pattern_o(pat), .pattern_valid_o(val));
    tvgbs_mem_model mem (.clk_i(clk), .addr_stb_i(adr), .rd_n_i(rd_n), .desc_stb_i(chr),
        .oe_i(oe), .dev_i(dout), .bus_o(bus), .lat_o(lat));

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic clear();
        {n_row, n_chr, n_adr, n_rd, n_wr, n_hand, n_val, n_oe} = '0;
    endtask

    // Tally strobes; judge the per-cycle relations inside a fetch
    always @(posedge clk) begin
        if (cnt_en) begin
            n_row += int'(row_n === 1'b0);
            n_chr += int'(chr === 1'b1);
            n_adr += int'(adr === 1'b1);
            n_rd += int'(rd_n === 1'b0);
            n_wr += int'(wr_n === 1'b0);
            n_hand += int'(hand === 1'b1);
            n_val += int'(val === 1'b1);
            n_oe += int'(oe === 1'b1);
            if (row_n === 1'b0) check("char with row", 1, chr);
            if (infr && adr === 1'b1 && n_hand == 0) check("oe at addr", 1, oe);
            if (infr && val === 1'b1) check("pattern", lat[7:0] ^ 8'h5a, pat);
        end
    end

    // Each code held four cycles, then idle, in processor mode
    task automatic code_scan();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            clear();
            cnt_en = 1;
            code = c;
            repeat (4) @(posedge clk);
            #1 code = 3'h0;
            repeat (5) @(posedge clk);
            #1 cnt_en = 0;
            check("char", c == 3'h2 || c == 3'h4 || c == 3'h6, n_chr > 0);
            check("addr", c == 3'h4, n_adr > 0);
            check("read", c == 3'h3, n_rd > 0);
            check("write", c == 3'h5, n_wr > 0);
            check("oe", 0, n_oe);
        end
    endtask

    // One frame with a foreign code held during the fetch
    task automatic frame_run(logic ex, logic [2:0] held);
        int rows, w;
        rows = ex ? 14 : 13;
        extra = ex;
        clear();
        cnt_en = 1;
        infr = 1;
        frame = 1;
        w = 0;
        while (n_adr == 0 && w < 100) begin
            @(posedge clk);
            #1 w++;
        end
        check("object address", `TVGBS_PAT_BASE, dout);
        code = held;
        while (n_hand == 0 && w < 40000) begin
            @(posedge clk);
            #1 w++;
        end
        // Last pattern byte lands after handoff; the held code is honoured there
        code = 3'h0;
        @(posedge clk);
        #1 {cnt_en, infr, frame} = '0;
        check("handoff", 1, n_hand);
        check("rows", rows, n_row);
        check("chars", rows * 320 + int'(held inside {3'h2, 3'h4, 3'h6}), n_chr);
        check("addr", 8 + rows * 320 + int'(held == 3'h4), n_adr);
        check("read", 8 + rows * 320, n_rd);
        check("write", 0, n_wr);
        check("valid", 8 + rows * 320, n_val);
        repeat (4) @(posedge clk);
        #1 check("idle oe", 0, oe);
    endtask

    // Clock at 200 MHz
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    // Watchdog well past two frames
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {srst, frame, extra, cnt_en, infr, code} = 8'h80;
        {num_errors, checks} = '0;
        repeat (6) @(posedge clk);
        #1 srst = 0;
        check("reset oe", 0, oe);
        check("reset strobes", 3'h7, {row_n, rd_n, wr_n});
        code_scan();
        frame_run(1'b0, 3'h6);
        frame_run(1'b1, 3'h4);
        code_scan();
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: sim/tvgbs_mem_model.sv
/*
 * Pattern and descriptor memory model on the shared 14-bit bus.
 * Assumes registered strobes from the sequencer in the clk_i domain.
 */
`timescale 1ns/1ps
`default_nettype none
module tvgbs_mem_model (
    input wire logic clk_i,
    input wire logic addr_stb_i,
    input wire logic rd_n_i,
    input wire logic desc_stb_i,
    input wire logic oe_i,
    input wire logic [13:0] dev_i,
    output logic [13:0] bus_o,
    output logic [13:0] lat_o
);
    logic [13:0] last_r; // Last level seen on the bus

    // Latch the strobed address and track the bus level
    always_ff @(posedge clk_i) begin
        if (addr_stb_i) begin
            lat_o <= bus_o;
        end
        last_r <= bus_o;
    end

    // Resolve the bus; a released bus never holds its old level
    always_comb begin
        if (oe_i) begin
            bus_o = dev_i;
        end else if (!rd_n_i) begin
            bus_o = {6'h00, lat_o[7:0] ^ 8'h5a};
        end else if (desc_stb_i) begin
            bus_o = 14'h01a5;
        end else begin
            bus_o = ~last_r;
        end
    end
endmodule
`default_nettype wire

// file: src/tvgbs_decoder.sv
/*
 * Decodes the processor three-wire control code.
 * Assumes the code is already synchronised to clk.
 */
`timescale 1ns/1ps
`include "tvgbs_defines.svh"
`default_nettype none
module tvgbs_decoder (
    tvgbs_if.dec bus
);
    // Codes matter only in processor mode
    always_comb begin
        bus.fetch_req = 1'b0;
        bus.write_req = 1'b0;
        bus.read_req = 1'b0;
        bus.alat_req = 1'b0;
        if (bus.cpu_mode) begin
            bus.fetch_req = (bus.code == `TVGBS_CODE_ALAT) || (bus.code == `TVGBS_CODE_IND)
                || (bus.code == `TVGBS_CODE_DWR);
            bus.write_req = (bus.code == `TVGBS_CODE_WSTB);
            bus.read_req = (bus.code == `TVGBS_CODE_READ);
            bus.alat_req = (bus.code == `TVGBS_CODE_ALAT);
        end
    end
endmodule
`default_nettype wire

// file: src/tvgbs_defines.svh
/*
 * Timing and geometry constants for the display-fetch bus sequencer.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TVGBS_DEFINES_SVH
`define TVGBS_DEFINES_SVH

`define TVGBS_BUS_W 14
`define TVGBS_COLS 5'h14
`define TVGBS_ROWS 4'hc
`define TVGBS_LINES 5'h10
`define TVGBS_OBJS 4'h8
`define TVGBS_DESC_BASE 14'h0200
`define TVGBS_PAT_BASE 14'h3000
`define TVGBS_CODE_IDLE 3'h0
`define TVGBS_CODE_IVEC 3'h1
`define TVGBS_CODE_IND 3'h2
`define TVGBS_CODE_READ 3'h3
`define TVGBS_CODE_ALAT 3'h4
`define TVGBS_CODE_WSTB 3'h5
`define TVGBS_CODE_DWR 3'h6
`define TVGBS_CODE_IACK 3'h7

`endif

// file: src/tvgbs_if.sv
/*
 * Carrier between the sequencer and its processor code decoder.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface tvgbs_if;
    logic [2:0] code; // Synchronised processor control code
    logic cpu_mode; // Processor-controlled mode active
    logic fetch_req; // Decoded request for a char fetch strobe
    logic write_req; // Decoded write-strobe code
    logic read_req; // Decoded read code
    logic alat_req; // Decoded address-latch code
    modport seq (output code, output cpu_mode, input fetch_req, input write_req,
        input read_req, input alat_req);
    modport dec (input code, input cpu_mode, output fetch_req, output write_req,
        output read_req, output alat_req);
endinterface
`default_nettype wire

// file: src/tvgbs_pkg.sv
/*
 * Types for the display-fetch bus sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tvgbs_pkg;
    // Fetch sequencer phases
    typedef enum logic [2:0] {
        TVGBS_CPU, TVGBS_OBJ_ADR, TVGBS_OBJ_RD, TVGBS_DESC, TVGBS_PAT_ADR, TVGBS_PAT_RD
    } tvgbs_phase_e;
endpackage

// file: src/tvgbs_sequencer.sv
/*
 * Display-fetch sequencer of a TV display interface: frame and row
 * strobes, graphics memory control bus, shared 14-bit bus.
 * Assumes frame_start_i and cpu code pins are asynchronous pins,
 * synchronised here; the bus is resolved outside from bus_oe_o.
 */
// Summary of operation
// - Eight positioned objects, sixteen colours, concurrent
// - Background twelve rows by twenty columns
// - Descriptors: 240 words of 14 bits
// - One shared bidirectional 14-bit bus
// - Frame handoff strobe once per frame
// - Row fetch thirteen or fourteen per frame
// - Row fetch low on first line of row
// - Char fetch pulse per character position
// - Remaining fifteen lines use char fetch alone
// - Char fetch on latch, indirect, data-write codes
// - Address strobe only with valid pattern address; a latch code at frame start strobes in the first fetch cycle, bus released
// - Write strobe writes latched address
// - Graphics bus fetches, else serves processor
// - Codes honoured only in processor mode
`timescale 1ns/1ps
`include "tvgbs_defines.svh"
`default_nettype none
module tvgbs_sequencer #(
    parameter int OBJS = `TVGBS_OBJS,
    parameter logic [4:0] COLS = `TVGBS_COLS,
    parameter logic [3:0] ROWS = `TVGBS_ROWS,
    parameter logic [4:0] LINES = `TVGBS_LINES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic frame_start_i, // Frame begin pin, async
    input wire logic row_extra_i, // Picture offset: one more row
    input wire logic cpu_bus_direction_i,
    input wire logic cpu_ctl_line_one_i,
    input wire logic cpu_ctl_line_two_i,
    input wire logic [`TVGBS_BUS_W-1:0] bus_in_i,
    output logic [`TVGBS_BUS_W-1:0] bus_out_o,
    output logic bus_oe_o,
    output logic frame_handoff_strobe_o,
    output logic row_fetch_request_n_o,
    output logic char_fetch_strobe_o,
    output logic gfx_addr_strobe_o,
    output logic gfx_read_strobe_n_o,
    output logic gfx_write_strobe_n_o,
    output logic [7:0] pattern_o, // Last fetched pattern byte
    output logic pattern_valid_o
);
    // Whole state of the block
    typedef struct packed {
        logic [1:0] fs_sync; // Frame pin synchroniser
        logic [5:0] code_sync; // Code pin synchroniser, two stages
        logic fs_last; // Previous synchronised frame level
        tvgbs_pkg::tvgbs_phase_e phase;
        logic [3:0] obj; // Object index
        logic [3:0] row; // Background row
        logic [4:0] line; // Line within row
        logic [4:0] col; // Column within row
        logic [2:0] code_prev; // Synchronised code one cycle older
        logic fetch_rd; // Fetch read strobe stands this cycle
        logic [13:0] bus_out;
        logic bus_oe;
        logic handoff;
        logic row_req_n;
        logic char_fetch;
        logic addr_stb;
        logic rd_n;
        logic wr_n;
        logic [7:0] pattern;
        logic pat_valid;
    } tvgbs_state_s;

    tvgbs_state_s st_r, st_nxt;
    tvgbs_if dif ();
    logic frame_rise;
    logic [3:0] rows_total;

    // Pins are synchronised bit by bit; a code counts once two cycles agree
    assign dif.code = (st_r.code_sync[5:3] == st_r.code_prev) ? st_r.code_sync[5:3]
        : `TVGBS_CODE_IDLE;
    assign dif.cpu_mode = (st_r.phase == tvgbs_pkg::TVGBS_CPU);
    tvgbs_decoder u_dec (.bus(dif));

    assign frame_rise = st_r.fs_sync[1] & ~st_r.fs_last;
    assign rows_total = row_extra_i ? (ROWS + 4'h2) : (ROWS + 4'h1);

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.fs_sync = {st_r.fs_sync[0], frame_start_i};
        st_nxt.fs_last = st_r.fs_sync[1];
        st_nxt.code_sync = {st_r.code_sync[2:0], cpu_bus_direction_i,
            cpu_ctl_line_one_i, cpu_ctl_line_two_i};
        st_nxt.code_prev = st_r.code_sync[5:3];
        // Pulse outputs default inactive, bus released
        st_nxt.handoff = 1'b0;
        st_nxt.row_req_n = 1'b1;
        st_nxt.char_fetch = 1'b0;
        st_nxt.addr_stb = 1'b0;
        st_nxt.rd_n = 1'b1;
        st_nxt.wr_n = 1'b1;
        st_nxt.bus_oe = 1'b0;
        st_nxt.pat_valid = 1'b0;
        st_nxt.fetch_rd = 1'b0;
        // Take the pattern byte while the fetch read strobe stands
        if (st_r.fetch_rd) begin
            st_nxt.pattern = bus_in_i[7:0];
            st_nxt.pat_valid = 1'b1;
        end
        unique case (st_r.phase)
            tvgbs_pkg::TVGBS_CPU: begin
                // Processor owns the graphics bus
                st_nxt.char_fetch = dif.fetch_req;
                st_nxt.addr_stb = dif.alat_req;
                st_nxt.rd_n = ~dif.read_req;
                st_nxt.wr_n = ~dif.write_req;
                if (frame_rise) begin
                    st_nxt.phase = tvgbs_pkg::TVGBS_OBJ_ADR;
                    st_nxt.obj = 4'h0;
                    st_nxt.row = 4'h0;
                    st_nxt.line = 5'h0;
                    st_nxt.col = 5'h0;
                end
            end
            tvgbs_pkg::TVGBS_OBJ_ADR: begin
                // Present object pattern address
                st_nxt.bus_out = `TVGBS_PAT_BASE + {10'h0, st_r.obj};
                st_nxt.bus_oe = 1'b1;
                st_nxt.addr_stb = 1'b1;
                st_nxt.phase = tvgbs_pkg::TVGBS_OBJ_RD;
            end
            tvgbs_pkg::TVGBS_OBJ_RD: begin
                st_nxt.rd_n = 1'b0;
                st_nxt.fetch_rd = 1'b1;
                if (st_r.obj == 4'(OBJS - 1)) begin
                    st_nxt.phase = tvgbs_pkg::TVGBS_DESC;
                end else begin
                    st_nxt.obj = st_r.obj + 4'h1;
                    st_nxt.phase = tvgbs_pkg::TVGBS_OBJ_ADR;
                end
            end
            tvgbs_pkg::TVGBS_DESC: begin
                // Descriptor read: row strobe only on first line
                st_nxt.char_fetch = 1'b1;
                st_nxt.row_req_n = ~((st_r.line == 5'h0) && (st_r.col == 5'h0));
                st_nxt.phase = tvgbs_pkg::TVGBS_PAT_ADR;
            end
            tvgbs_pkg::TVGBS_PAT_ADR: begin
                // Descriptor stands on the bus under the char fetch strobe
                st_nxt.bus_out = {bus_in_i[13:3], st_r.line[2:0]};
                st_nxt.bus_oe = 1'b1;
                st_nxt.addr_stb = 1'b1;
                st_nxt.phase = tvgbs_pkg::TVGBS_PAT_RD;
            end
            tvgbs_pkg::TVGBS_PAT_RD: begin
                st_nxt.rd_n = 1'b0;
                st_nxt.fetch_rd = 1'b1;
                st_nxt.phase = tvgbs_pkg::TVGBS_DESC;
                if (st_r.col != COLS - 5'h1) begin
                    st_nxt.col = st_r.col + 5'h1;
                end else begin
                    st_nxt.col = 5'h0;
                    if (st_r.line != LINES - 5'h1) begin
                        st_nxt.line = st_r.line + 5'h1;
                    end else begin
                        st_nxt.line = 5'h0;
                        if (st_r.row == rows_total - 4'h1) begin
                            st_nxt.phase = tvgbs_pkg::TVGBS_CPU;
                            st_nxt.handoff = 1'b1;
                        end else begin
                            st_nxt.row = st_r.row + 4'h1;
                        end
                    end
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= '0;
            st_r.phase <= tvgbs_pkg::TVGBS_CPU;
            st_r.row_req_n <= 1'b1;
            st_r.rd_n <= 1'b1;
            st_r.wr_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus_out_o = st_r.bus_out;
    assign bus_oe_o = st_r.bus_oe;
    assign frame_handoff_strobe_o = st_r.handoff;
    assign row_fetch_request_n_o = st_r.row_req_n;
    assign char_fetch_strobe_o = st_r.char_fetch;
    assign gfx_addr_strobe_o = st_r.addr_stb;
    assign gfx_read_strobe_n_o = st_r.rd_n;
    assign gfx_write_strobe_n_o = st_r.wr_n;
    assign pattern_o = st_r.pattern;
    assign pattern_valid_o = st_r.pat_valid;

    // Assertions
    // Strobes decided in processor mode may still show in the first fetch cycle
    a_strobe_with_bus: assert property (@(posedge clk_i) disable iff (srst_i)
        gfx_addr_strobe_o && !$past(dif.cpu_mode) |-> bus_oe_o)
        else $error("strobe without address");
    a_bus_release: assert property (@(posedge clk_i) disable iff (srst_i)
        dif.cpu_mode |=> !bus_oe_o) else $error("bus not released");
    a_ignore_codes: assert property (@(posedge clk_i) disable iff (srst_i)
        !dif.cpu_mode && st_r.phase != tvgbs_pkg::TVGBS_PAT_RD |=> gfx_write_strobe_n_o)
        else $error("code honoured in fetch");
    a_fetch_code: assert property (@(posedge clk_i) disable iff (srst_i)
        dif.cpu_mode && dif.code == `TVGBS_CODE_DWR && !frame_rise |=> char_fetch_strobe_o)
        else $error("no fetch on data write");
    a_row_with_char: assert property (@(posedge clk_i) disable iff (srst_i)
        !row_fetch_request_n_o |-> char_fetch_strobe_o) else $error("row strobe alone");
    a_handoff_mode: assert property (@(posedge clk_i) disable iff (srst_i)
        frame_handoff_strobe_o |-> dif.cpu_mode ##1 !frame_handoff_strobe_o)
        else $error("handoff not single");
    a_row_first_line: assert property (@(posedge clk_i) disable iff (srst_i)
        !row_fetch_request_n_o |-> $past(st_r.line) == 5'h0) else $error("row strobe late");
    a_write_code: assert property (@(posedge clk_i) disable iff (srst_i)
        dif.cpu_mode && dif.code == `TVGBS_CODE_WSTB && !frame_rise |=> !gfx_write_strobe_n_o)
        else $error("write strobe missed");
endmodule
`default_nettype wire
